// ==== lscd_defs.svh ====
// Constants for the low-side channel control and diagnostic block.
`ifndef LSCD_DEFS_SVH
`define LSCD_DEFS_SVH
`define LSCD_CLK_HZ          40000000
`define LSCD_DEGL_SHORT_NS   3500
`define LSCD_DEGL_LONG_NS    10000
`define LSCD_RETRY_MS        100
`define LSCD_DEGL_SHORT_CYC  ((`LSCD_DEGL_SHORT_NS * 40 + 999) / 1000)
`define LSCD_DEGL_LONG_CYC   ((`LSCD_DEGL_LONG_NS * 40 + 999) / 1000)
`define LSCD_RETRY_CYC       (`LSCD_RETRY_MS * (`LSCD_CLK_HZ / 1000))
`define LSCD_CRC_POLY        5'h13
`define LSCD_CRC_INIT        4'h0
`define LSCD_ADR_CTRL        4'h0
`define LSCD_ADR_CHON        4'h1
`define LSCD_ADR_OCMASK      4'h2
`define LSCD_ADR_OLMASK      4'h3
`define LSCD_ADR_OLFLAG      4'h4
`define LSCD_ADR_OCFLAG      4'h5
`define LSCD_ADR_STATUS      4'h6
`define LSCD_ADR_CMD         4'h7
`define LSCD_ADR_CRCIN       4'h8
`define LSCD_ADR_CRCOUT      4'h9
`define LSCD_CTRL_PAIR       0
`define LSCD_CTRL_LONG       1
`define LSCD_CTRL_RETRY      2
`define LSCD_CTRL_FORCE      3
`define LSCD_CMD_CLR_ALL     0
`define LSCD_CMD_CLEAR_OPEN_CMD    1
`define LSCD_CMD_CLR_OC      2
`define LSCD_ST_ANY_OPEN     0
`define LSCD_ST_ANY_OC       1
`define LSCD_ST_SUMMARY      2
`define LSCD_ST_THERMAL      3
`define LSCD_ST_PWM          4
`endif

// ==== lscd_load_model.sv ====
// Model of the PWM source and of the eight switched loads.
`timescale 1ns/1ps
`default_nettype none
module lscd_load_model (
	input  wire logic [3:0] pwm_req_i,
	input  wire logic [7:0] open_ld_i,
	input  wire logic [7:0] short_ld_i,
	input  wire logic [7:0] drive_i,
	input  wire logic [7:0] sink_en_i,
	output logic      [3:0] pwm_in_n_o,
	output logic      [7:0] open_cmp_o,
	output logic      [7:0] overcurrent_o
);
	assign pwm_in_n_o = ~pwm_req_i;
	// A missing load is only pulled low by the sink while the switch is off.
	assign open_cmp_o = open_ld_i & sink_en_i & ~drive_i;
	assign overcurrent_o = short_ld_i & drive_i;
endmodule // lscd_load_model
`default_nettype wire

// ==== lscd_pkg.sv ====
// Types for the low-side channel control and diagnostic block.
package lscd_pkg;
	typedef enum logic [1:0] {LSCD_RT_IDLE, LSCD_RT_WAIT} lscd_retry_t;
endpackage

// ==== lscd_top.sv ====
// Eight-channel low-side control, fault detection and check-value logic.
// How it works
// - Check value: zero-padded MSB-first division by 0x13.
// - Channel on bit turns channel on.
// - Four active-low PWM inputs request conduction.
// - Direct map: PWM one to four drive one-four.
// - Pair map: each PWM drives adjacent channel pair.
// - PWM pin levels are readable by software.
// - Fault output pulled low on any open or overcurrent fault.
// - Force bit pulls fault output low.
// - Open detection only while off, sets flag.
// - Open load never blocks switching on.
// - Open flag cleared by commands or mask.
// - Open mask disables detection and sink current.
// - Open fault sets summary flags and output.
// - Persistent overcurrent while on sets flag, turns off.
// - Overcurrent shutdown latches until cleared.
// - Deglitch 3.5 us normal, 10 us long.
// - Overcurrent mask ignores detection, keeps channel on.
// - Overcurrent sets summary flags and output.
// - Auto retry re-enables after 100 ms.
// - Flags stay set during retry wait.
// - One retry timer shared by all channels.
// - Enable pin high turns all channels off.
// - Thermal shutdown turns all channels off.
`include "lscd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lscd_top
	import lscd_pkg::*;
#(
	parameter int NCH       = 8,
	parameter int RETRY_CYC = `LSCD_RETRY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  pwm_in_n_i,
	input  wire logic        outputs_enable_n_i,
	input  wire logic        thermal_i,
	input  wire logic [7:0]  open_cmp_i,
	input  wire logic [7:0]  overcurrent_i,
	output logic      [7:0]  channel_drive_o,
	output logic      [7:0]  open_sink_en_o,
	output logic             fault_out_n_o,
	output logic             fault_out_n_oe_o
);
	localparam int DSHORT = `LSCD_DEGL_SHORT_CYC;
	localparam int DLONG  = `LSCD_DEGL_LONG_CYC;

	// One MSB-first division step of the check value.
	function automatic logic [3:0] crc_step(input logic [3:0] c,
		input logic b);
		logic [4:0] t;
		t = {c, b};
		if (t[4])
			t = t ^ `LSCD_CRC_POLY;
		return t[3:0];
	endfunction

	// Three-stage synchronisers for all asynchronous pins.
	logic [15:0] s1_reg, s2_reg, s3_reg;
	logic [7:0]  ol_s1_reg, ol_s2_reg, ol_s3_reg;
	wire  [15:0] async_in = {thermal_i, outputs_enable_n_i, pwm_in_n_i,
		overcurrent_i, 2'h0};
	// Stages reset to the idle pin levels: PWM inactive, outputs disabled.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg    <= 16'h7C00;
			s2_reg    <= 16'h7C00;
			s3_reg    <= 16'h7C00;
			ol_s1_reg <= 8'h00;
			ol_s2_reg <= 8'h00;
			ol_s3_reg <= 8'h00;
		end else begin
			s1_reg    <= async_in;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			ol_s1_reg <= open_cmp_i;
			ol_s2_reg <= ol_s1_reg;
			ol_s3_reg <= ol_s2_reg;
		end
	end
	// A level counts once the second and third stages agree.
	logic [15:0] flt_reg;
	logic [7:0]  ol_flt_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flt_reg    <= 16'h7C00;
			ol_flt_reg <= 8'h00;
		end else begin
			flt_reg    <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
			ol_flt_reg <= (ol_s2_reg & ol_s3_reg)
				| (ol_flt_reg & (ol_s2_reg | ol_s3_reg));
		end
	end
	wire [7:0] oc_raw     = flt_reg[9:2];
	wire [3:0] pwm_lvl    = flt_reg[13:10];
	wire       oe_n_lvl   = flt_reg[14];
	wire       thermal    = flt_reg[15];
	wire [3:0] pwm_active = ~pwm_lvl;

	// Software registers.
	logic [3:0] ctrl_reg;
	logic [7:0] chon_reg, ocmask_reg, olmask_reg;
	logic [7:0] olflag_reg, ocflag_reg, ocoff_reg;
	logic [7:0] crc_in_reg;
	logic [3:0] crc_out_reg;
	wire pair_map_sel      = ctrl_reg[`LSCD_CTRL_PAIR];
	wire long_deglitch_sel = ctrl_reg[`LSCD_CTRL_LONG];
	wire auto_retry_sel    = ctrl_reg[`LSCD_CTRL_RETRY];
	wire fault_force       = ctrl_reg[`LSCD_CTRL_FORCE];

	// Wishbone decode: one-cycle ack, writes on low byte lane.
	wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [3:0] widx    = wb_adr_i[5:2];
	wire       wr_lo   = req & wb_we_i & wb_sel_i[0];
	wire       wr_ctrl = wr_lo & (widx == `LSCD_ADR_CTRL);
	wire       wr_chon = wr_lo & (widx == `LSCD_ADR_CHON);
	wire       wr_ocm  = wr_lo & (widx == `LSCD_ADR_OCMASK);
	wire       wr_olm  = wr_lo & (widx == `LSCD_ADR_OLMASK);
	wire       wr_cmd  = wr_lo & (widx == `LSCD_ADR_CMD);
	wire       wr_crc  = wr_lo & (widx == `LSCD_ADR_CRCIN);
	wire clear_all_faults_cmd  = wr_cmd & wb_dat_i[`LSCD_CMD_CLR_ALL];
	wire clear_open_cmd        = wr_cmd & wb_dat_i[`LSCD_CMD_CLEAR_OPEN_CMD];
	wire clear_overcurrent_cmd = wr_cmd & wb_dat_i[`LSCD_CMD_CLR_OC];

	// Channel request mapping.
	wire [7:0] pwm_map = pair_map_sel ?
		{{2{pwm_active[3]}}, {2{pwm_active[2]}},
		 {2{pwm_active[1]}}, {2{pwm_active[0]}}} :
		{4'h0, pwm_active};
	wire [7:0] req_on   = chon_reg | pwm_map;
	wire       all_off  = oe_n_lvl | thermal;
	// Open flags do not appear here, so an open load never blocks.
	wire [7:0] drive_next = all_off ? 8'h00 : (req_on & ~ocoff_reg);
	logic [7:0] drive_reg;

	// Deglitch counters, one per channel.
	localparam int DW = $clog2(DLONG + 1);
	logic [DW-1:0] degl_reg [NCH];
	wire  [DW-1:0] degl_lim = long_deglitch_sel ? DW'(DLONG) : DW'(DSHORT);
	wire  [7:0]    oc_watch = drive_reg & oc_raw & ~ocmask_reg;
	logic [7:0]    oc_trip;
	always_comb begin
		for (int i = 0; i < NCH; i++)
			oc_trip[i] = oc_watch[i] && (degl_reg[i] >= degl_lim - 1'b1);
	end
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < NCH; i++) begin
			if (rst_i || !oc_watch[i])
				degl_reg[i] <= '0;
			else if (!oc_trip[i])
				degl_reg[i] <= degl_reg[i] + 1'b1;
		end
	end

	// Shared retry timer.
	localparam int RW = $clog2(RETRY_CYC + 1);
	lscd_retry_t   rt_state_reg;
	logic [RW-1:0] rt_cnt_reg;
	wire rt_done = (rt_state_reg == LSCD_RT_WAIT)
		&& (rt_cnt_reg == RW'(RETRY_CYC - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rt_state_reg <= LSCD_RT_IDLE;
			rt_cnt_reg   <= '0;
		end else begin
			case (rt_state_reg)
				LSCD_RT_IDLE: begin
					rt_cnt_reg <= '0;
					if (auto_retry_sel && (ocoff_reg != 8'h00))
						rt_state_reg <= LSCD_RT_WAIT;
				end
				LSCD_RT_WAIT: begin
					rt_cnt_reg <= rt_cnt_reg + 1'b1;
					if (rt_done || !auto_retry_sel)
						rt_state_reg <= LSCD_RT_IDLE;
				end
				default: rt_state_reg <= LSCD_RT_IDLE;
			endcase
		end
	end

	// Open detection: only while off and unmasked; set wins over clear.
	wire [7:0] ol_det   = ol_flt_reg & ~drive_reg & ~olmask_reg;
	wire       ol_clr   = clear_all_faults_cmd | clear_open_cmd;
	wire [7:0] ol_next  = (ol_clr ? 8'h00 : olflag_reg) & ~olmask_reg
		| ol_det;
	wire       oc_clr   = clear_all_faults_cmd | clear_overcurrent_cmd;
	// The flag stays through the retry wait; only the off latch is released.
	wire [7:0] oc_next  = ((oc_clr ? 8'h00 : ocflag_reg) | oc_trip)
		& ~ocmask_reg;
	wire [7:0] off_next = (((oc_clr | rt_done) ? 8'h00 : ocoff_reg)
		| oc_trip) & ~ocmask_reg;
	wire any_open = |olflag_reg;
	wire any_oc   = |ocflag_reg;
	wire summary  = any_open | any_oc;
	wire fault_low_next = (|ol_next) | (|oc_next) | fault_force;

	// Check value over the eight-bit input, zero-padded by four bits.
	logic [3:0] crc_calc;
	always_comb begin
		crc_calc = `LSCD_CRC_INIT;
		for (int i = 11; i >= 0; i--)
			crc_calc = crc_step(crc_calc,
				(i >= 4) ? crc_in_reg[i-4] : 1'b0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg    <= 4'h0;
			chon_reg    <= 8'h00;
			ocmask_reg  <= 8'h00;
			olmask_reg  <= 8'h00;
			olflag_reg  <= 8'h00;
			ocflag_reg  <= 8'h00;
			ocoff_reg   <= 8'h00;
			crc_in_reg  <= 8'h00;
			crc_out_reg <= 4'h0;
			drive_reg   <= 8'h00;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= wb_dat_i[3:0];
			if (wr_chon)
				chon_reg <= wb_dat_i[7:0];
			if (wr_ocm)
				ocmask_reg <= wb_dat_i[7:0];
			if (wr_olm)
				olmask_reg <= wb_dat_i[7:0];
			if (wr_crc)
				crc_in_reg <= wb_dat_i[7:0];
			crc_out_reg <= crc_calc;
			olflag_reg  <= ol_next;
			ocflag_reg  <= oc_next;
			ocoff_reg   <= off_next;
			drive_reg   <= drive_next;
		end
	end

	// Outputs and read mux.
	wire [7:0] status_rd = {pwm_active, thermal, summary, any_oc,
		any_open};
	wire [7:0] rd_mux =
		(widx == `LSCD_ADR_CTRL)    ? {4'h0, ctrl_reg} :
		(widx == `LSCD_ADR_CHON)    ? chon_reg :
		(widx == `LSCD_ADR_OCMASK)  ? ocmask_reg :
		(widx == `LSCD_ADR_OLMASK)  ? olmask_reg :
		(widx == `LSCD_ADR_OLFLAG)  ? olflag_reg :
		(widx == `LSCD_ADR_OCFLAG)  ? ocflag_reg :
		(widx == `LSCD_ADR_STATUS)  ? status_rd :
		(widx == `LSCD_ADR_CRCIN)   ? crc_in_reg :
		(widx == `LSCD_ADR_CRCOUT)  ? {4'h0, crc_out_reg} : 8'h00;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o         <= 1'b0;
			wb_dat_o         <= 32'h0000_0000;
			channel_drive_o  <= 8'h00;
			open_sink_en_o   <= 8'h00;
			fault_out_n_o    <= 1'b0;
			fault_out_n_oe_o <= 1'b0;
		end else begin
			wb_ack_o         <= req;
			wb_dat_o         <= {24'h000000, rd_mux};
			channel_drive_o  <= drive_next;
			open_sink_en_o   <= ~drive_next & ~olmask_reg;
			fault_out_n_o    <= 1'b0;
			fault_out_n_oe_o <= fault_low_next;
		end
	end

	// Checks on channel mapping, fault handling and the bus.
	AST_MAP_DIRECT: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!pair_map_sel && !all_off && pwm_active[0] && !ocoff_reg[0])
		|-> ##1 drive_reg[0])
		else $error("pwm one not driving channel one");
	AST_MAP_HIGH: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!pair_map_sel && !all_off)
		|-> (drive_next[7:4] == (chon_reg[7:4] & ~ocoff_reg[7:4])))
		else $error("upper channels not following their bits");
	AST_MAP_PAIR: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(pair_map_sel && !all_off && pwm_active[3] && !ocoff_reg[7])
		|-> ##1 drive_reg[7])
		else $error("pwm four not driving channel eight");
	AST_ALL_OFF: assert property (
		@(posedge clk_i) disable iff (rst_i)
		all_off |-> ##1 (drive_reg == 8'h00))
		else $error("channels on while disabled");
	AST_THERMAL: assert property (
		@(posedge clk_i) disable iff (rst_i)
		thermal |-> ##1 (channel_drive_o == 8'h00))
		else $error("channels on while hot");
	AST_OC_OFF: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ocoff_reg[0] |-> !drive_next[0])
		else $error("tripped channel driven");
	AST_OC_LATCH: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ocoff_reg[3] && !oc_clr && !rt_done && !ocmask_reg[3])
		|-> ##1 ocoff_reg[3])
		else $error("overcurrent latch released early");
	AST_OC_TRIP: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(oc_watch[0] && !long_deglitch_sel
			&& degl_reg[0] == DW'(DSHORT - 1))
		|-> ##1 (ocflag_reg[0] && ocoff_reg[0]))
		else $error("overcurrent not flagged after short deglitch");
	AST_OC_LONG: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(oc_watch[0] && long_deglitch_sel
			&& degl_reg[0] == DW'(DLONG - 1))
		|-> ##1 (ocflag_reg[0] && ocoff_reg[0]))
		else $error("overcurrent not flagged after long deglitch");
	AST_OC_EARLY: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(oc_watch[0] && degl_reg[0] < DW'(DSHORT - 1))
		|-> ##1 !ocoff_reg[0])
		else $error("overcurrent shut off before deglitch");
	AST_OC_MASK: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ocmask_reg[1] |-> ##1 !ocoff_reg[1])
		else $error("masked channel shut off");
	AST_OL_MASK: assert property (
		@(posedge clk_i) disable iff (rst_i)
		olmask_reg[2] |-> ##1 (!olflag_reg[2] && !open_sink_en_o[2]))
		else $error("masked open still active");
	AST_OL_SET: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ol_flt_reg[3] && !drive_reg[3] && !olmask_reg[3])
		|-> ##1 olflag_reg[3])
		else $error("open load not flagged");
	AST_OL_ON: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(olflag_reg[2] && !all_off && chon_reg[2] && !ocoff_reg[2])
		|-> ##1 drive_reg[2])
		else $error("open load blocked the channel");
	AST_OL_CLR: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(ol_clr && !ol_det[1]) |-> ##1 !olflag_reg[1])
		else $error("open flag survived clear");
	AST_SINK_OFF: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> ((open_sink_en_o & channel_drive_o) == 8'h00))
		else $error("sink current on a conducting channel");
	AST_FAULT_PIN: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(summary || $past(fault_force)) |-> fault_out_n_oe_o)
		else $error("fault pin released during fault");
	AST_FAULT_IDLE: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(!summary && !$past(fault_force)) |-> !fault_out_n_oe_o)
		else $error("fault pin pulled without fault");
	AST_PIN_LOW: assert property (
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> !fault_out_n_o)
		else $error("open drain data not low");
	AST_RETRY_FLAG: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rt_state_reg == LSCD_RT_WAIT && ocflag_reg[0] && !oc_clr
			&& !ocmask_reg[0])
		|-> ##1 ocflag_reg[0])
		else $error("flag dropped during retry");
	AST_RETRY_REL: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rt_done && !oc_trip[0]) |-> ##1 !ocoff_reg[0])
		else $error("channel not released at retry");
	AST_RETRY_HOLD: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(rt_state_reg == LSCD_RT_WAIT && !rt_done && auto_retry_sel)
		|-> ##1 (rt_state_reg == LSCD_RT_WAIT))
		else $error("shared retry wait cut short");
	AST_ACK_PULSE: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> ##1 !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	COV_PAIR: cover property (@(posedge clk_i) pair_map_sel && drive_reg[7]);
	COV_TRIP: cover property (@(posedge clk_i) |oc_trip);
	COV_LONG: cover property (@(posedge clk_i) long_deglitch_sel && |oc_trip);
	COV_RETRY: cover property (@(posedge clk_i) rt_done);
	COV_OPEN: cover property (@(posedge clk_i) |olflag_reg);
endmodule // lscd_top
`default_nettype wire

// ==== lscd_top_test.sv ====
// Self-checking bench for the low-side channel control block.
`timescale 1ns/1ps
`default_nettype none
module lscd_top_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  pwm_req = 4'h0;
	logic        en_n = 1'b0;
	logic        hot = 1'b0;
	logic [7:0]  open_ld = 8'h00;
	logic [7:0]  short_ld = 8'h00;
	logic [3:0]  pwm_n;
	logic [7:0]  ocmp, oc, drive, sink, q;
	logic        fo, foe;
	int          error_cnt = 0;
	int          n_compared = 0;
	logic [23:0] rows [8];
	logic [7:0]  msg [4] = '{8'h00, 8'h01, 8'h80, 8'hA5};

	lscd_top #(.RETRY_CYC(50)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pwm_in_n_i(pwm_n),
		.outputs_enable_n_i(en_n), .thermal_i(hot), .open_cmp_i(ocmp),
		.overcurrent_i(oc), .channel_drive_o(drive), .open_sink_en_o(sink),
		.fault_out_n_o(fo), .fault_out_n_oe_o(foe));

	lscd_load_model i_load (
		.pwm_req_i(pwm_req), .open_ld_i(open_ld), .short_ld_i(short_ld),
		.drive_i(drive), .sink_en_i(sink), .pwm_in_n_o(pwm_n),
		.open_cmp_o(ocmp), .overcurrent_o(oc));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic complete_run;
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		bus(1'b1, i, d);
	endtask

	task automatic rd(input logic [3:0] i, input string nm, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(nm, q, e);
	endtask

	task automatic ocp(input logic [7:0] c, input int t_on, input int t_off);
		wr(4'h0, c);
		short_ld <= 8'h01;
		wr(4'h1, 8'h01);
		wt(t_on);
		chk("oc pending", drive, 8'h01);
		wt(t_off - t_on);
		chk("oc off", drive, 8'h00);
		rd(4'h5, "oc flag", 8'h01);
	endtask

	function automatic logic [3:0] crc4(input logic [7:0] m);
		logic [4:0]  r;
		logic [11:0] s;
		r = 5'h00;
		s = {m, 4'h0};
		for (int i = 11; i >= 0; i--) begin
			r = {r[3:0], s[i]};
			if (r[4])
				r = r ^ 5'h13;
		end
		return r[3:0];
	endfunction

	initial begin
		wt(100000);
		error_cnt++;
		complete_run();
	end

	initial begin
		rows = '{24'h000101, 24'h000F0F, 24'h0F00F0, 24'h100103,
			24'h100ACC, 24'h100430, 24'h005207, 24'h180183};
		wt(16);
		rst_i <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			wr(4'h0, {4'h0, rows[k][23:20]});
			wr(4'h1, rows[k][19:12]);
			pwm_req <= rows[k][11:8];
			wt(8);
			chk("drive", drive, rows[k][7:0]);
			rd(4'h6, "status", {rows[k][11:8], 4'h0});
		end
		pwm_req <= 4'h0;
		wr(4'h0, 8'h00);
		wr(4'h1, 8'hFF);
		en_n <= 1'b1;
		wt(8);
		chk("drive disabled", drive, 8'h00);
		en_n <= 1'b0;
		wt(8);
		chk("drive enabled", drive, 8'hFF);
		rd(4'h1, "on bits kept", 8'hFF);
		hot <= 1'b1;
		wt(8);
		chk("drive hot", drive, 8'h00);
		hot <= 1'b0;
		wr(4'h0, 8'h08);
		wt(4);
		chk("fault forced", {6'h00, foe, fo}, 8'h02);
		wr(4'h0, 8'h00);
		wt(4);
		chk("fault idle", {6'h00, foe, fo}, 8'h00);
		wr(4'h1, 8'h00);
		open_ld <= 8'h04;
		wt(8);
		chk("sink", sink, 8'hFF);
		rd(4'h4, "open flag", 8'h04);
		rd(4'h6, "status open", 8'h05);
		chk("fault open", {7'h00, foe}, 8'h01);
		wr(4'h1, 8'h04);
		wt(8);
		chk("drive open", drive, 8'h04);
		wr(4'h7, 8'h02);
		rd(4'h4, "open cleared", 8'h00);
		wr(4'h1, 8'h00);
		wt(8);
		wr(4'h3, 8'h04);
		wt(4);
		chk("sink masked", sink, 8'hFB);
		rd(4'h4, "open masked", 8'h00);
		wr(4'h3, 8'h00);
		open_ld <= 8'h00;
		wt(8);
		wr(4'h7, 8'h01);
		rd(4'h6, "status clear", 8'h00);
		ocp(8'h00, 130, 165);
		rd(4'h6, "status oc", 8'h06);
		short_ld <= 8'h00;
		wt(20);
		chk("latched", drive, 8'h00);
		wr(4'h7, 8'h04);
		wt(4);
		chk("oc cleared", drive, 8'h01);
		ocp(8'h02, 385, 420);
		wr(4'h2, 8'h01);
		wt(450);
		chk("oc masked", drive, 8'h01);
		rd(4'h5, "oc mask flag", 8'h00);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h04);
		short_ld <= 8'h03;
		wr(4'h1, 8'h03);
		wt(170);
		chk("retry off", drive, 8'h00);
		rd(4'h6, "retry status", 8'h06);
		wt(60);
		chk("retry on", drive, 8'h03);
		rd(4'h5, "retry flag", 8'h03);
		short_ld <= 8'h00;
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h01);
		foreach (msg[k]) begin
			wr(4'h8, msg[k]);
			rd(4'h9, "check", {4'h0, crc4(msg[k])});
		end
		wr(4'hF, 8'hFF);
		rd(4'hF, "unmapped", 8'h00);
		wr(4'h1, 8'hFF);
		rst_i <= 1'b1;
		wt(4);
		rst_i <= 1'b0;
		rd(4'h1, "on bits reset", 8'h00);
		chk("drive reset", drive, 8'h00);
		complete_run();
	end
endmodule // lscd_top_test
`default_nettype wire
